// ==== rtl/legacy_io_adapter_pkg.sv ====
// constants, register map and carrier types of the legacy byte-wide port adapter
// assumes a classic wishbone master with 32-bit data and byte addresses
// Function
// - internal tick period is 1.27655 microseconds; the code rounds down to 31 clocks at 25 MHz, 1.24 microseconds
// - port data and direction at fixed offsets
// - timer bytes placed at their fixed offsets
// - each port is eight bidirectional bits
// - each port has its own direction register
// - unused bits read zero when inputs
// - port a bit 3 selects serial clock
// - bit 4 routes channel a request to bit 7
// - bit 6 routes channel b request to bit 7
// - bit 7 reads the routed request state
// - direction bit one drives, zero inputs
// - enable register mirrors flag register positions
package legacy_io_adapter_pkg;

    localparam int unsigned CLK_FREQ_HZ      = 25000000;
    localparam real         TICK_PERIOD_US   = 1.27655;
    localparam int unsigned TICK_CYCLES      =
        (int'(TICK_PERIOD_US * real'(CLK_FREQ_HZ) / 1.0E6) < 1) ? 1 :
        int'($floor(TICK_PERIOD_US * real'(CLK_FREQ_HZ) / 1.0E6));

    localparam int unsigned ADDR_W = 13;

    localparam logic [12:0] OFS_PORT_B_DATA   = 13'h0000;
    localparam logic [12:0] OFS_PORT_A_DATA   = 13'h0200;
    localparam logic [12:0] OFS_PORT_B_DIR    = 13'h0400;
    localparam logic [12:0] OFS_PORT_A_DIR    = 13'h0600;
    localparam logic [12:0] OFS_T1_COUNT_LO   = 13'h0800;
    localparam logic [12:0] OFS_T1_COUNT_HI   = 13'h0A00;
    localparam logic [12:0] OFS_T1_LATCH_LO   = 13'h0C00;
    localparam logic [12:0] OFS_T1_LATCH_HI   = 13'h0E00;
    localparam logic [12:0] OFS_T2_COUNT_LO   = 13'h1000;
    localparam logic [12:0] OFS_T2_COUNT_HI   = 13'h1200;
    localparam logic [12:0] OFS_SHIFTER       = 13'h1400;
    localparam logic [12:0] OFS_AUX_CONTROL   = 13'h1600;
    localparam logic [12:0] OFS_PIN_CONTROL   = 13'h1800;
    localparam logic [12:0] OFS_EVENT_FLAGS   = 13'h1A00;
    localparam logic [12:0] OFS_EVENT_ENABLES = 13'h1C00;
    localparam logic [12:0] OFS_PORT_A_ALIAS  = 13'h1E00;

    localparam int unsigned NUM_REGS      = 16;
    localparam int unsigned REG_SEL_LSB   = 9;
    localparam int unsigned REG_SEL_W     = 4;
    localparam logic [8:0]  REG_STEP_MASK = 9'h1FF;

    localparam int unsigned BIT_CLOCK_SEL  = 3;
    localparam int unsigned BIT_CHAN_A_EN  = 4;
    localparam int unsigned BIT_CHAN_B_EN  = 6;
    localparam int unsigned BIT_REQUEST_IN = 7;

    localparam logic [7:0] PORT_A_UNUSED_MASK = 8'h27;
    localparam logic [7:0] PORT_B_UNUSED_MASK = 8'hFF;
    localparam logic [7:0] BYTE_RESET         = 8'h00;
    localparam logic [7:0] PORT_A_DIR_RESET   = 8'h58;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_ACK  = 3'h4
    } bus_state_type;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } port_drive_type;

    typedef struct packed {
        logic wait_request_a_n;
        logic wait_request_b_n;
    } serial_request_type;

endpackage

// ==== rtl/legacy_io_adapter.sv ====
// register window and port logic of the legacy byte-wide port adapter
// assumes one 25 MHz clock, synchronous pins, and a classic wishbone master
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module legacy_io_adapter #(
    parameter int unsigned TICK_LEN = legacy_io_adapter_pkg::TICK_CYCLES
) (
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    input  wire logic                                   cyc_i,
    input  wire logic                                   stb_i,
    input  wire logic                                   we_i,
    input  wire logic [31:0]                            adr_i,
    input  wire logic [3:0]                             sel_i,
    input  wire logic [31:0]                            dat_i,
    output logic      [31:0]                            dat_o,
    output logic                                        ack_o,
    input  wire logic [7:0]                             port_a_in_i,
    input  wire logic [7:0]                             port_b_in_i,
    output legacy_io_adapter_pkg::port_drive_type       port_a_o,
    output legacy_io_adapter_pkg::port_drive_type       port_b_o,
    input  wire legacy_io_adapter_pkg::serial_request_type serial_request_i,
    output logic                                        chan_a_rxtx_clock_select_o
);

    typedef struct packed {
        legacy_io_adapter_pkg::bus_state_type state;
        logic [15:0]                          tick;
        logic [127:0]                         regs;
        logic [7:0]                           rdata;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic [3:0] idx;
    logic       hit;
    logic [7:0] port_a_rd;
    logic [7:0] port_b_rd;
    logic       request_n;
    logic [7:0] reg_a_data;
    logic [7:0] reg_a_dir;
    logic [7:0] reg_b_data;
    logic [7:0] reg_b_dir;

    assign idx = adr_i[legacy_io_adapter_pkg::REG_SEL_LSB +: legacy_io_adapter_pkg::REG_SEL_W];
    // whole window is 0x0000..0x1FFF; every register owns one aligned word per 0x200
    assign hit = (adr_i[31:legacy_io_adapter_pkg::ADDR_W] == '0)
               && ((adr_i[8:0] & legacy_io_adapter_pkg::REG_STEP_MASK) == 9'h000);

    assign reg_b_data = s_q.regs[8*0 +: 8];
    assign reg_a_data = s_q.regs[8*1 +: 8];
    assign reg_b_dir  = s_q.regs[8*2 +: 8];
    assign reg_a_dir  = s_q.regs[8*3 +: 8];

    // active-low wired combination of the selected channels
    always_comb begin
        request_n = 1'b1;
        if (reg_a_data[legacy_io_adapter_pkg::BIT_CHAN_A_EN]) begin
            request_n = request_n & serial_request_i.wait_request_a_n;
        end
        if (reg_a_data[legacy_io_adapter_pkg::BIT_CHAN_B_EN]) begin
            request_n = request_n & serial_request_i.wait_request_b_n;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            always_comb begin
                if (reg_a_dir[g]) begin
                    port_a_rd[g] = reg_a_data[g];
                end else if (g == legacy_io_adapter_pkg::BIT_REQUEST_IN) begin
                    port_a_rd[g] = request_n;
                end else if (legacy_io_adapter_pkg::PORT_A_UNUSED_MASK[g]) begin
                    port_a_rd[g] = 1'b0;
                end else begin
                    port_a_rd[g] = port_a_in_i[g];
                end
                if (reg_b_dir[g]) begin
                    port_b_rd[g] = reg_b_data[g];
                end else if (legacy_io_adapter_pkg::PORT_B_UNUSED_MASK[g]) begin
                    port_b_rd[g] = 1'b0;
                end else begin
                    port_b_rd[g] = port_b_in_i[g];
                end
            end
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        case (s_q.state)
            legacy_io_adapter_pkg::ST_IDLE: begin
                if (cyc_i && stb_i) begin
                    s_d.state = legacy_io_adapter_pkg::ST_WAIT;
                    s_d.tick  = 16'(TICK_LEN - 1);
                end
            end
            legacy_io_adapter_pkg::ST_WAIT: begin
                // each access takes one internal tick, like the legacy part
                if (s_q.tick != 16'h0000) begin
                    s_d.tick = s_q.tick - 16'h0001;
                end else begin
                    s_d.state = legacy_io_adapter_pkg::ST_ACK;
                    s_d.rdata = 8'h00;
                    if (hit) begin
                        case (idx)
                            4'h0: s_d.rdata = port_b_rd;
                            4'h1: s_d.rdata = port_a_rd;
                            4'hF: s_d.rdata = port_a_rd;
                            default: s_d.rdata = s_q.regs[8*idx +: 8];
                        endcase
                        if (we_i && sel_i[0]) begin
                            if (idx == 4'hF) begin
                                s_d.regs[8*1 +: 8] = dat_i[7:0];
                            end else begin
                                s_d.regs[8*idx +: 8] = dat_i[7:0];
                            end
                        end
                    end
                end
            end
            legacy_io_adapter_pkg::ST_ACK: begin
                s_d.state = legacy_io_adapter_pkg::ST_IDLE;
            end
            default: begin
                s_d.state = legacy_io_adapter_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.state <= legacy_io_adapter_pkg::ST_IDLE;
            s_q.tick  <= 16'h0000;
            s_q.rdata <= legacy_io_adapter_pkg::BYTE_RESET;
            s_q.regs  <= '0;
            s_q.regs[8*3 +: 8] <= legacy_io_adapter_pkg::PORT_A_DIR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign ack_o = (s_q.state == legacy_io_adapter_pkg::ST_ACK) && cyc_i && stb_i;
    assign dat_o = {24'h000000, s_q.rdata};

    assign port_a_o.out  = reg_a_data;
    assign port_a_o.oe_n = ~reg_a_dir;
    assign port_b_o.out  = reg_b_data;
    assign port_b_o.oe_n = ~reg_b_dir;
    // 1 selects external serial clock, 0 the 3.6864 MHz clock
    assign chan_a_rxtx_clock_select_o = reg_a_data[legacy_io_adapter_pkg::BIT_CLOCK_SEL];

endmodule

// ==== tb/legacy_io_adapter_chk.sv ====
// checker: bus answer timing, read lanes and port drive of the adapter
// assumes it is bound into legacy_io_adapter and sees only its ports
`timescale 1ns/1ps
module legacy_io_adapter_chk #(parameter int unsigned TICK_LEN = 2) (
    input wire logic                                  clk_i,
    input wire logic                                  rst_i,
    input wire logic                                  cyc_i,
    input wire logic                                  stb_i,
    input wire logic                                  we_i,
    input wire logic [31:0]                           adr_i,
    input wire logic [3:0]                            sel_i,
    input wire logic [31:0]                           dat_i,
    input wire logic [31:0]                           dat_o,
    input wire logic                                  ack_o,
    input wire legacy_io_adapter_pkg::port_drive_type port_a_o,
    input wire legacy_io_adapter_pkg::port_drive_type port_b_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    int unsigned n_q;
    // wait count of the open request; an idle bus or the answer clears it
    always_ff @(posedge clk_i) n_q <= (rst_i || !(cyc_i && stb_i) || ack_o) ? 0 : n_q + 1;
    a_ack_time: assert property (ack_o |-> n_q == TICK_LEN + 1) else $error("ack off time");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_byte_lane: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("high lanes");
    a_unused_b: assert property (ack_o && !we_i && adr_i == 32'h0
        |-> (dat_o[7:0] & port_b_o.oe_n) == 8'h00) else $error("port b input set");
    a_unused_a: assert property (ack_o && !we_i && adr_i == 32'h200
        |-> (dat_o[7:0] & port_a_o.oe_n & 8'h27) == 8'h00) else $error("port a unused set");
    a_out_read: assert property (ack_o && !we_i && adr_i == 32'h200
        |-> (dat_o[7:0] & ~port_a_o.oe_n) == (port_a_o.out & ~port_a_o.oe_n))
        else $error("port a output misread");
    a_data_write: assert property (ack_o && we_i && sel_i[0] && adr_i == 32'h200
        |=> port_a_o.out == $past(dat_i[7:0])) else $error("port a data lost");
    a_dir_write: assert property (ack_o && we_i && sel_i[0] && adr_i == 32'h400
        |=> port_b_o.oe_n == ~$past(dat_i[7:0])) else $error("port b direction lost");
endmodule
bind legacy_io_adapter legacy_io_adapter_chk #(.TICK_LEN(TICK_LEN)) i_chk (.clk_i, .rst_i,
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .port_a_o, .port_b_o);

// ==== tb/serial_ctrl_model.sv ====
// serial controller stand-in driving the two active-low wait/request lines
// assumes want_i changes just after a rising edge; no request means high
`timescale 1ns/1ps
module serial_ctrl_model (
    input  wire logic [1:0]                           want_i,
    output legacy_io_adapter_pkg::serial_request_type req_o
);
    assign req_o = {~want_i[0], ~want_i[1]};
endmodule

// ==== tb/testbench.sv ====
// bench: classic wishbone accesses against expected register and pin values
// assumes the adapter at TICK_LEN 2 and the serial controller stand-in
`timescale 1ns/1ps
module testbench;
    logic                                      clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0;
    logic                                      ack, csel;
    logic [31:0]                               adr = 32'h0, wdat = 32'h0, dat, r;
    logic [3:0]                                sel = 4'h0;
    logic [1:0]                                want = 2'h0;
    legacy_io_adapter_pkg::port_drive_type     pa, pb;
    legacy_io_adapter_pkg::serial_request_type sreq;
    int                                        err_total = 0, num_checks = 0;
    always #20 clk = ~clk;
    legacy_io_adapter #(.TICK_LEN(2)) i_legacy_io_adapter (.clk_i(clk), .rst_i(rst),
        .cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(dat), .ack_o(ack), .port_a_in_i(8'hFF), .port_b_in_i(8'hFF), .port_a_o(pa),
        .port_b_o(pb), .serial_request_i(sreq), .chan_a_rxtx_clock_select_o(csel));
    serial_ctrl_model i_serial_ctrl_model (.want_i(want), .req_o(sreq));
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ack is sampled at the rising edge, before that edge's own updates land
    task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'h1);
        @(posedge clk);
        req <= 1'b1;
        {we, adr, sel, wdat} <= {w, a, s, 24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = dat;
        req <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(r, {24'h0, e});
    endtask
    initial begin
        #400000;
        err_total++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(32'h600, 8'h58);
        for (int i = 4; i < 15; i++) wb(1'b1, i * 32'h200, 8'hA0 + 8'(i));
        for (int i = 4; i < 15; i++) rd(i * 32'h200, 8'hA0 + 8'(i));
        wb(1'b1, 32'h400, 8'hFF);
        wb(1'b1, 32'h0, 8'h5A);
        rd(32'h0, 8'h5A);
        wb(1'b1, 32'h400, 8'h0F);
        rd(32'h0, 8'h0A);
        rd(32'h600, 8'h58);
        chk({16'h0, pb}, 32'h5AF0);
        wb(1'b1, 32'h200, 8'h08);
        rd(32'h200, 8'h88);
        chk({31'h0, csel}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            wb(1'b1, 32'h200, {1'b0, i[3], 1'b0, i[2], 4'h0});
            want <= i[1:0];
            rd(32'h200, {~(i[0] & i[2] | i[1] & i[3]), i[3], 1'b0, i[2], 4'h0});
        end
        chk({31'h0, csel}, 32'h0);
        wb(1'b1, 32'h210, 8'hFF);
        wb(1'b1, 32'h2200, 8'hFF);
        wb(1'b1, 32'h200, 8'hFF, 4'h0);
        rd(32'h1E00, 8'h50);
        rd(32'h100, 8'h00);
        wb(1'b1, 32'h1E00, 8'h08);
        chk({31'h0, csel}, 32'h1);
        test_done();
    end
endmodule
